// file: sim/flash_dev_model.sv
// behavioural model of the parallel flash device
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter real PROG_NS = 3000.0,
  parameter real ERASE_NS = 6000.0,
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'hC3 // arbitrary value
) (
  input wire logic [20:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] pd = 8'h00;
  logic [1:0] mode = 2'd0;
  logic tog = 1'b0;
  logic er = 1'b0;
  int step = 0;
  real t_fall = 0.0;
  real t_end = -9.0E3;
  wire rd_n = ce_n_i | oe_n_i;
  wire wr_n = we_n_i | ce_n_i | !oe_n_i;
  // command decoder
  task automatic wr(input logic [20:0] a, input logic [7:0] d);
    if (d == 8'hF0 && (step == 0 || step == 2))
      mode = 2'd0;
    case (step)
      0: step = (a == 21'h005555 && d == 8'hAA) ? 1 : 0;
      1: step = (a == 21'h002AAA && d == 8'h55) ? 2 : 0;
      2:
      begin
        step = (a == 21'h005555 && d == 8'hA0) ? 3 : (a == 21'h005555 && d == 8'h80) ? 4 : 0;
        if (a == 21'h005555 && d == 8'h90)
          mode = 2'd1;
        if (a == 21'h005555 && d == 8'h98)
          mode = 2'd2;
      end
      3:
      begin
        mem[a[15:0]] = mem[a[15:0]] & d;
        pd = d;
        er = 1'b0;
        t_end = $realtime + PROG_NS;
        step = 0;
      end
      4: step = (a == 21'h005555 && d == 8'hAA) ? 5 : 0;
      5: step = (a == 21'h002AAA && d == 8'h55) ? 6 : 0;
      default:
      begin
        step = 0;
        if (d == 8'h30 || d == 8'h50 || (d == 8'h10 && a == 21'h005555))
        begin
          for (int i = 0; i < 65536; i++)
            if (d != 8'h30 || i[15:12] == a[15:12])
              mem[i] = 8'hFF;
          er = 1'b1;
          t_end = $realtime + ERASE_NS;
        end
      end
    endcase
  endtask
  // array starts erased
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'hFF;
    dq_o = 8'h00;
  end
  // glitch filter timing
  always @(negedge wr_n)
    t_fall = $realtime;
  // latch on the rising edge, ignore while busy
  always @(posedge wr_n)
    if ($realtime - t_fall >= 5.0 && $realtime >= t_end)
      wr(addr_i, dq_i);
  // status or data on each read access
  always @(negedge rd_n)
  begin
    if ($realtime < t_end)
    begin
      tog = !tog;
      dq_o = {er ? 1'b0 : !pd[7], tog, 6'h2A};
    end
    else if ($realtime < t_end + 1000.0)
      dq_o = {mem[addr_i[15:0]][7], ~mem[addr_i[15:0]][6:0]};
    else if (mode == 2'd1)
      dq_o = addr_i == 21'h0 ? MAKER_ID : addr_i == 21'h1 ? DEV_ID : 8'h00;
    else if (mode == 2'd2)
      dq_o = addr_i == 21'h10 ? 8'h51 : 8'h00;
    else
      dq_o = mem[addr_i[15:0]];
  end
  // released bus shows the inverse of the last value
  always @(posedge rd_n)
    dq_o = ~dq_o;
endmodule
`default_nettype wire

// file: sim/flash_host_checker.sv
// pin protocol checker for the flash host
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_host_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [`FL_ADDR_W-1:0] fl_addr_o,
  input wire logic fl_chip_sel_n_o,
  input wire logic fl_out_gate_n_o,
  input wire logic fl_wr_strobe_n_o,
  input wire logic [`FL_DATA_W-1:0] fl_dq_o,
  input wire logic fl_dq_oe_o
);
  logic sq;
  logic wg;
  logic a55;
  logic [7:0] pd;
  logic [20:0] pa;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // write pulse start, and one that follows a 55 write
  assign wg = sq && !fl_wr_strobe_n_o;
  assign a55 = wg && pd == 8'h55;
  // previous strobe level
  always_ff @(posedge sys_clk_i)
    sq <= rst_i | fl_wr_strobe_n_o;
  // previous write data and address
  always_ff @(posedge sys_clk_i)
  begin
    if (wg)
    begin
      pd <= fl_dq_o;
      pa <= fl_addr_o;
    end
  end
  property p_inhibit; !fl_wr_strobe_n_o |-> fl_out_gate_n_o && !fl_chip_sel_n_o; endproperty
  a_inhibit: assert property (p_inhibit) else $error("strobe while inhibited");
  property p_width; wg |-> (!fl_wr_strobe_n_o) [*8]; endproperty
  a_width: assert property (p_width) else $error("short write pulse");
  property p_hold; !fl_wr_strobe_n_o && !sq |->
    fl_dq_oe_o && $stable(fl_dq_o) && $stable(fl_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("data moved in pulse");
  property p_release; !fl_out_gate_n_o |-> !fl_dq_oe_o; endproperty
  a_release: assert property (p_release) else $error("host drives in read");
  property p_unlock; wg && pd == 8'hAA && pa == `FL_ADDR_UNLOCK1 |->
    fl_dq_o == 8'h55 && fl_addr_o == `FL_ADDR_UNLOCK2; endproperty
  a_unlock: assert property (p_unlock) else $error("bad unlock step");
  property p_sector; a55 && fl_dq_o == 8'h30 |-> fl_addr_o[11:0] == 12'h000; endproperty
  a_sector: assert property (p_sector) else $error("sector not aligned");
  property p_block; a55 && fl_dq_o == 8'h50 |-> fl_addr_o[15:0] == 16'h0000; endproperty
  a_block: assert property (p_block) else $error("block not aligned");
  property p_chip; a55 && fl_dq_o == 8'h10 |-> fl_addr_o == `FL_ADDR_UNLOCK1; endproperty
  a_chip: assert property (p_chip) else $error("chip erase address");
  property p_query; a55 && fl_dq_o == 8'h98 |-> fl_addr_o == `FL_ADDR_UNLOCK1; endproperty
  a_query: assert property (p_query) else $error("query address");
  c_prog: cover property (a55 && fl_dq_o == 8'hA0);
  c_sect: cover property (a55 && fl_dq_o == 8'h30);
  c_read: cover property (!fl_out_gate_n_o ##1 fl_out_gate_n_o);
endmodule
bind flash_host flash_host_checker chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .fl_addr_o(fl_addr_o), .fl_chip_sel_n_o(fl_chip_sel_n_o), .fl_out_gate_n_o(fl_out_gate_n_o),
  .fl_wr_strobe_n_o(fl_wr_strobe_n_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o));
`default_nettype wire

// file: sim/test_flash_host.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module test_flash_host;
  import flash_host_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] av_addr = 4'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [20:0] fl_addr;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic [7:0] dq_host;
  logic [7:0] dq_dev;
  logic [7:0] dq_bus;
  logic dq_oe;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  // shared data wire
  assign dq_bus = dq_oe ? dq_host : dq_dev;
  flash_host DUT (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(av_addr),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
    .fl_addr_o(fl_addr), .fl_chip_sel_n_o(ce_n), .fl_out_gate_n_o(oe_n),
    .fl_wr_strobe_n_o(we_n), .fl_dq_i(dq_bus), .fl_dq_o(dq_host), .fl_dq_oe_o(dq_oe));
  flash_dev_model u_flash (.addr_i(fl_addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .dq_i(dq_bus), .dq_o(dq_dev));
  // clock
  always #2.5 clk = !clk;
  task automatic complete_run();
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one avalon transfer held until waitrequest drops
  task automatic av_xfer(input logic w, input logic [3:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    av_addr <= a;
    av_wd <= wd;
    av_wr <= w;
    av_rd <= !w;
    @(posedge clk);
    while (av_wait !== 1'b0)
      @(posedge clk);
    rd = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask
  // start a command and poll until idle
  task automatic go(input flash_cmd_t c, output logic [31:0] st);
    av_xfer(1'b1, `REG_CTRL, {25'h0, c, 4'h1}, st);
    st = 32'h1;
    while (st[0] !== 1'b0)
      av_xfer(1'b0, `REG_STATUS, 32'h0, st);
  endtask
  task automatic run(input flash_cmd_t c, input logic [20:0] a, input logic [7:0] d,
    input logic [8:0] ex);
    logic [31:0] x;
    av_xfer(1'b1, `REG_ADDR, {11'h0, a}, x);
    av_xfer(1'b1, `REG_WDATA, {24'h0, d}, x);
    go(c, x);
    chk("status", {29'h0, x[2:0]}, 32'h2);
    if (ex[8])
      chk("result", {24'h0, x[15:8]}, {24'h0, ex[7:0]});
  endtask
  // idle status and an unmapped offset
  task automatic t_reset();
    logic [31:0] x;
    av_xfer(1'b0, `REG_STATUS, 32'h0, x);
    chk("idle", {29'h0, x[2:0]}, 32'h0);
    av_xfer(1'b0, 4'h1, 32'h0, x);
    chk("unmapped", x, 32'h0);
  endtask
  // program both bit 7 polarities, then read back
  task automatic t_prog();
    run(CMD_PROGRAM, 21'h01234, 8'h5A, 9'h0);
    run(CMD_PROGRAM, 21'h01236, 8'hC3, 9'h0);
    run(CMD_READ, 21'h01234, 8'h00, 9'h15A);
    run(CMD_READ, 21'h01236, 8'h00, 9'h1C3);
  endtask
  // every erase kind, sector erase keeps its neighbour
  task automatic t_erase();
    flash_cmd_t ec [3] = '{CMD_SECTOR_ERASE, CMD_BLOCK_ERASE, CMD_CHIP_ERASE};
    run(CMD_PROGRAM, 21'h02345, 8'h33, 9'h0);
    for (int i = 0; i < 3; i++)
    begin
      run(CMD_PROGRAM, 21'h01234, 8'h00, 9'h0);
      run(ec[i], 21'h01234, 8'h00, 9'h0);
      run(CMD_READ, 21'h01234, 8'h00, 9'h1FF);
      if (i == 0)
        run(CMD_READ, 21'h02345, 8'h00, 9'h133);
    end
  endtask
  // identification and query modes with exit
  task automatic t_modes();
    run(CMD_ID_ENTRY, 21'h0, 8'h00, 9'h0);
    run(CMD_READ, 21'h0, 8'h00, 9'h13C);
    run(CMD_READ, 21'h1, 8'h00, 9'h1C3);
    run(CMD_EXIT, 21'h0, 8'h00, 9'h0);
    run(CMD_READ, 21'h0, 8'h00, 9'h1FF);
    run(CMD_QUERY_ENTRY, 21'h0, 8'h00, 9'h0);
    run(CMD_READ, 21'h10, 8'h00, 9'h151);
    run(CMD_READ, 21'h10, 8'h00, 9'h151);
    run(CMD_EXIT, 21'h0, 8'h00, 9'h0);
    run(CMD_READ, 21'h10, 8'h00, 9'h1FF);
  endtask
  // requests during a running program are dropped
  task automatic t_busy();
    logic [31:0] x;
    av_xfer(1'b1, `REG_ADDR, 32'h01238, x);
    av_xfer(1'b1, `REG_WDATA, 32'h3C, x);
    av_xfer(1'b1, `REG_CTRL, {25'h0, CMD_PROGRAM, 4'h1}, x);
    av_xfer(1'b1, `REG_ADDR, 32'h00777, x);
    go(CMD_EXIT, x);
    chk("busy_prog", {29'h0, x[2:0]}, 32'h2);
    // registers written while busy keep their earlier values
    av_xfer(1'b0, `REG_CTRL, 32'h0, x);
    chk("busy_cmd", x, {25'h0, CMD_PROGRAM, 4'h0});
    av_xfer(1'b0, `REG_ADDR, 32'h0, x);
    chk("busy_reg", x, 32'h0001238);
    av_xfer(1'b0, `REG_WDATA, 32'h0, x);
    chk("busy_data", x, 32'h0000003C);
    go(CMD_READ, x);
    chk("busy_addr", {24'h0, x[15:8]}, 32'h3C);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_prog();
    t_erase();
    t_modes();
    t_busy();
    complete_run();
  end
endmodule
`default_nettype wire

// file: src/flash_bus_cycle.sv
// one timed read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_bus_cycle (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [`FL_ADDR_W-1:0] addr_i,
  input wire logic [`FL_DATA_W-1:0] wdata_i,
  output logic done_o,
  output logic [`FL_DATA_W-1:0] rdata_o,
  output logic [`FL_ADDR_W-1:0] fl_addr_o,
  output logic fl_chip_sel_n_o,
  output logic fl_out_gate_n_o,
  output logic fl_wr_strobe_n_o,
  input wire logic [`FL_DATA_W-1:0] fl_dq_i,
  output logic [`FL_DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_o
);
  import flash_host_pkg::*;

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_ACTIVE = 2'b01,
    CY_RECOVER = 2'b10
  } cycle_state_t;

  localparam int PULSE_CYC = `T_PULSE_CYC;
  localparam int READ_CYC = `T_READ_CYC;

  cycle_state_t state;
  logic [7:0] count;
  logic is_write;

  // sequence one strobe, then a gap as long as a write pulse
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state <= CY_IDLE;
      count <= 8'h00;
      is_write <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      fl_addr_o <= '0;
      fl_dq_o <= 8'h00;
      fl_chip_sel_n_o <= 1'b1;
      fl_out_gate_n_o <= 1'b1;
      fl_wr_strobe_n_o <= 1'b1;
      fl_dq_oe_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state)
        CY_IDLE:
        begin
          if (start_i)
          begin
            is_write <= write_i;
            fl_addr_o <= addr_i;
            fl_dq_o <= wdata_i;
            fl_dq_oe_o <= write_i;
            fl_chip_sel_n_o <= 1'b0;
            fl_out_gate_n_o <= write_i;
            fl_wr_strobe_n_o <= ~write_i;
            count <= write_i ? 8'(PULSE_CYC) : 8'(READ_CYC);
            state <= CY_ACTIVE;
          end
        end
        CY_ACTIVE:
        begin
          if (count == 8'h01)
          begin
            if (!is_write)
              rdata_o <= fl_dq_i;
            fl_chip_sel_n_o <= 1'b1;
            fl_out_gate_n_o <= 1'b1;
            fl_wr_strobe_n_o <= 1'b1;
            count <= 8'(PULSE_CYC);
            state <= CY_RECOVER;
          end
          else
            count <= count - 8'h01;
        end
        CY_RECOVER:
        begin
          fl_dq_oe_o <= 1'b0;
          if (count == 8'h01)
          begin
            done_o <= 1'b1;
            state <= CY_IDLE;
          end
          else
            count <= count - 8'h01;
        end
        default: state <= CY_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: src/flash_host.sv
// flash host controller: avalon registers to command sequences and status polling
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_host (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [`FL_ADDR_W-1:0] fl_addr_o,
  output logic fl_chip_sel_n_o,
  output logic fl_out_gate_n_o,
  output logic fl_wr_strobe_n_o,
  input wire logic [`FL_DATA_W-1:0] fl_dq_i,
  output logic [`FL_DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_o
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_POLL = 3'b011,
    ST_POLL_WAIT = 3'b100,
    ST_SETTLE = 3'b101
  } host_state_t;

  localparam int SETTLE_CYC = `T_SETTLE_CYC;

  host_state_t state;
  flash_cmd_t cmd;
  logic [`FL_ADDR_W-1:0] target_addr;
  logic [`FL_DATA_W-1:0] target_data;
  logic busy;
  logic done;
  logic fail;
  logic [`FL_DATA_W-1:0] result;
  logic [2:0] step;
  logic [2:0] last_step;
  logic first_poll;
  logic prev_toggle;
  logic [31:0] poll_count;
  logic [15:0] settle_count;
  logic cyc_start;
  logic cyc_write;
  logic [`FL_ADDR_W-1:0] cyc_addr;
  logic [`FL_DATA_W-1:0] cyc_wdata;
  logic cyc_done;
  logic [`FL_DATA_W-1:0] cyc_rdata;
  logic bus_ack;
  logic go_req;
  logic is_erase;
  logic [`FL_ADDR_W-1:0] seq_addr;
  logic [`FL_DATA_W-1:0] seq_data;

  flash_bus_cycle u_cycle (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(cyc_start),
    .write_i(cyc_write),
    .addr_i(cyc_addr),
    .wdata_i(cyc_wdata),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .fl_addr_o(fl_addr_o),
    .fl_chip_sel_n_o(fl_chip_sel_n_o),
    .fl_out_gate_n_o(fl_out_gate_n_o),
    .fl_wr_strobe_n_o(fl_wr_strobe_n_o),
    .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o)
  );

  // bus answers one cycle after a request appears
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;
  assign go_req = avs_write_i & bus_ack & (avs_address_i == `REG_CTRL)
    & avs_byteenable_i[0] & avs_writedata_i[`CTRL_GO_BIT];
  assign is_erase = (cmd == CMD_SECTOR_ERASE) | (cmd == CMD_BLOCK_ERASE)
    | (cmd == CMD_CHIP_ERASE);

  // acknowledge strobe for the avalon slave
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
  end

  // read data mux, unmapped offsets read zero
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_address_i == `REG_CTRL)
      avs_readdata_o <= {25'h0, cmd, 4'h0}; // cmd read back in bits 6:4, go reads 0
    else if (avs_address_i == `REG_ADDR)
      avs_readdata_o <= {11'h0, target_addr};
    else if (avs_address_i == `REG_WDATA)
      avs_readdata_o <= {24'h0, target_data};
    else if (avs_address_i == `REG_STATUS)
      avs_readdata_o <= {16'h0, result, 5'h0, fail, done, busy};
    else
      avs_readdata_o <= 32'h0000_0000;
  end

  // address and data registers, frozen while busy
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      target_addr <= '0;
      target_data <= 8'h00;
      cmd <= CMD_READ;
    end
    else if (avs_write_i && bus_ack && !busy)
    begin
      if (avs_address_i == `REG_ADDR)
        target_addr <= avs_writedata_i[`FL_ADDR_W-1:0];
      else if (avs_address_i == `REG_WDATA && avs_byteenable_i[0])
        target_data <= avs_writedata_i[7:0];
      else if (avs_address_i == `REG_CTRL && avs_byteenable_i[0])
        cmd <= flash_cmd_t'(avs_writedata_i[`CTRL_CMD_LSB +: 3]);
    end
  end

  // writes of the current step; prefix is sent for every command but read
  always_comb
  begin
    seq_addr = `FL_ADDR_UNLOCK1;
    seq_data = `FL_CODE_AA;
    last_step = 3'd2;
    case (step)
      3'd1:
      begin
        seq_addr = `FL_ADDR_UNLOCK2;
        seq_data = `FL_CODE_55;
      end
      3'd2:
      begin
        case (cmd)
          CMD_PROGRAM: seq_data = `FL_CODE_PROG;
          CMD_ID_ENTRY: seq_data = `FL_CODE_ID;
          CMD_QUERY_ENTRY: seq_data = `FL_CODE_QUERY;
          CMD_EXIT: seq_data = `FL_CODE_EXIT;
          default: seq_data = `FL_CODE_ERASE;
        endcase
      end
      3'd3:
      begin
        if (cmd == CMD_PROGRAM)
        begin
          seq_addr = target_addr;
          seq_data = target_data;
        end
      end
      3'd4:
      begin
        seq_addr = `FL_ADDR_UNLOCK2;
        seq_data = `FL_CODE_55;
      end
      3'd5:
      begin
        if (cmd == CMD_SECTOR_ERASE)
        begin
          seq_addr = {target_addr[`FL_ADDR_W-1:`FL_SECTOR_LSB], 12'h000};
          seq_data = `FL_CODE_SECTOR;
        end
        else if (cmd == CMD_BLOCK_ERASE)
        begin
          seq_addr = {target_addr[`FL_ADDR_W-1:`FL_BLOCK_LSB], 16'h0000};
          seq_data = `FL_CODE_BLOCK;
        end
        else
          seq_data = `FL_CODE_CHIP;
      end
      default:
      begin
        seq_addr = `FL_ADDR_UNLOCK1;
        seq_data = `FL_CODE_AA;
      end
    endcase
    if (cmd == CMD_PROGRAM)
      last_step = 3'd3;
    else if (is_erase)
      last_step = 3'd5;
  end

  // command sequencer and status polling
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      result <= 8'h00;
      step <= 3'd0;
      first_poll <= 1'b0;
      prev_toggle <= 1'b0;
      poll_count <= 32'h0000_0000;
      settle_count <= 16'h0000;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= '0;
      cyc_wdata <= 8'h00;
    end
    else
    begin
      cyc_start <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (go_req)
          begin
            busy <= 1'b1;
            done <= 1'b0;
            fail <= 1'b0;
            step <= 3'd0;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          cyc_start <= 1'b1;
          if (cmd == CMD_READ)
          begin
            cyc_write <= 1'b0;
            cyc_addr <= target_addr;
          end
          else
          begin
            cyc_write <= 1'b1;
            cyc_addr <= seq_addr;
            cyc_wdata <= seq_data;
          end
          state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (cyc_done)
          begin
            if (cmd == CMD_READ)
            begin
              result <= cyc_rdata;
              busy <= 1'b0;
              done <= 1'b1;
              state <= ST_IDLE;
            end
            else if (step == last_step)
            begin
              if (cmd == CMD_PROGRAM || is_erase)
              begin
                first_poll <= 1'b1;
                poll_count <= 32'h0000_0000;
                state <= ST_POLL;
              end
              else
              begin
                busy <= 1'b0;
                done <= 1'b1;
                state <= ST_IDLE;
              end
            end
            else
            begin
              step <= step + 3'd1;
              state <= ST_ISSUE;
            end
          end
        end
        ST_POLL:
        begin
          cyc_start <= 1'b1;
          cyc_write <= 1'b0;
          cyc_addr <= target_addr;
          state <= ST_POLL_WAIT;
        end
        ST_POLL_WAIT:
        begin
          if (cyc_done)
          begin
            first_poll <= 1'b0;
            prev_toggle <= cyc_rdata[6];
            poll_count <= poll_count + 32'h0000_0001;
            if (!first_poll && cyc_rdata[6] == prev_toggle)
            begin
              // toggling stopped; data-poll bit must agree
              if (cmd == CMD_PROGRAM)
                fail <= cyc_rdata[7] != target_data[7];
              else
                fail <= ~cyc_rdata[7];
              settle_count <= 16'(SETTLE_CYC);
              state <= ST_SETTLE;
            end
            else if (poll_count == `POLL_LIMIT)
            begin
              fail <= 1'b1;
              busy <= 1'b0;
              done <= 1'b1;
              state <= ST_IDLE;
            end
            else
              state <= ST_POLL;
          end
        end
        ST_SETTLE:
        begin
          // full byte is valid only after the settle interval
          if (settle_count == 16'h0001)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end
          else
            settle_count <= settle_count - 16'h0001;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: src/flash_host_cfg.svh
// constants and register map for the parallel flash host controller
// Notes on behaviour
// - wait 1 us before trusting full byte
// - poll only after last write pulse rises
// - toggle status valid only after last pulse
// - unlock prefix before program, six writes erase
// - query entry ends with 98H at 5555H
// - query mode held until exit command
// - sector erase 30H, block erase 50H last
// - chip erase 10H at 5555H last
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// flash pin widths
`define FL_ADDR_W 21
`define FL_DATA_W 8

// command addresses and codes
`define FL_ADDR_UNLOCK1 21'h005555
`define FL_ADDR_UNLOCK2 21'h002AAA
`define FL_CODE_AA 8'hAA
`define FL_CODE_55 8'h55
`define FL_CODE_PROG 8'hA0
`define FL_CODE_ERASE 8'h80
`define FL_CODE_SECTOR 8'h30
`define FL_CODE_BLOCK 8'h50
`define FL_CODE_CHIP 8'h10
`define FL_CODE_ID 8'h90
`define FL_CODE_QUERY 8'h98
`define FL_CODE_EXIT 8'hF0
`define FL_SECTOR_LSB 12
`define FL_BLOCK_LSB 16

// avalon register byte offsets
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_STATUS 4'hC
// control fields: bit 0 go, bits 6:4 command
`define CTRL_GO_BIT 0
`define CTRL_CMD_LSB 4
// status fields
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_FAIL_BIT 2
`define STAT_RDATA_LSB 8

// timing, 200 MHz clock
`define CLK_PERIOD_PS 5000
`define T_PULSE_PS 40000
`define T_PULSE_CYC ((`T_PULSE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_SETTLE_NS 1000
`define T_SETTLE_CYC ((`T_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_READ_PS 100000
`define T_READ_CYC ((`T_READ_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define POLL_LIMIT 32'd400000

`endif

// file: src/flash_host_pkg.sv
// types shared by the flash host controller
`default_nettype none
package flash_host_pkg;
  typedef enum logic [2:0] {
    CMD_READ = 3'b000,
    CMD_PROGRAM = 3'b001,
    CMD_SECTOR_ERASE = 3'b010,
    CMD_BLOCK_ERASE = 3'b011,
    CMD_CHIP_ERASE = 3'b100,
    CMD_ID_ENTRY = 3'b101,
    CMD_QUERY_ENTRY = 3'b110,
    CMD_EXIT = 3'b111
  } flash_cmd_t;
endpackage
`default_nettype wire
